/* File: design/uspc_hold.sv */
// Pulse stretcher: output stays high at least HOLD cycles
`timescale 1ns/1ps
`default_nettype none
module uspc_hold #(
	parameter int HOLD = 16
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic ce,
	input  wire logic trig,
	output var  logic active
);
	localparam int CW = $clog2(HOLD + 1);
	localparam logic [CW-1:0] LOAD = CW'(HOLD - 1);
	logic [CW-1:0] cnt;
	wire           busy = (cnt != '0);

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt    <= '0;
			active <= 1'b0;
		end else if (ce) begin
			// Retrigger reloads, so the hold runs from the last request
			cnt    <= trig ? LOAD : (busy ? cnt - 1'b1 : cnt);
			active <= trig | busy;
		end
	end
endmodule // uspc_hold
`default_nettype wire

/* File: design/uspc_persist.sv */
// Persistence timer: flags a condition held for CYC cycles
`timescale 1ns/1ps
`default_nettype none
module uspc_persist #(
	parameter int CYC = 16
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic ce,
	input  wire logic cond,
	output var  logic expired
);
	localparam int CW = $clog2(CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(CYC - 1);
	logic [CW-1:0] cnt;
	wire           at_last = (cnt == LAST);
	wire [CW-1:0]  next_cnt = !cond ? '0 : (at_last ? cnt : cnt + 1'b1);

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt     <= '0;
			expired <= 1'b0;
		end else if (ce) begin
			cnt     <= next_cnt;
			expired <= cond & at_last;
		end
	end
endmodule // uspc_persist
`default_nettype wire

/* File: design/uspc_top.sv */
// Dual USB port power switch control: enables, faults, converter_raise_n, limits
//
// Chosen here: the register addresses and the strobed register port.
`include "uspc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module uspc_top #(
	parameter int MASK_CYC  = (`USPC_MASK_NS + `USPC_CLK_NS - 1) / `USPC_CLK_NS,
	parameter int SHORT_CYC = `USPC_SHORT_NS / `USPC_CLK_NS,
	parameter int RISE_CYC  = (`USPC_RISE_NS + `USPC_CLK_NS - 1) / `USPC_CLK_NS,
	parameter int CYCLE_CYC = (`USPC_CYCLE_NS + `USPC_CLK_NS - 1) / `USPC_CLK_NS,
	parameter int HOLD_CYC  = (`USPC_HOLD_NS + `USPC_CLK_NS - 1) / `USPC_CLK_NS
) (
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire logic                 ce,
	input  wire logic [`USPC_AW-1:0]  reg_addr,
	input  wire logic [`USPC_DW-1:0]  reg_wdata,
	input  wire logic                 reg_write,
	input  wire logic                 reg_read,
	output var  logic [`USPC_DW-1:0]  reg_rdata,
	input  wire logic [3:0]           mode_limit_strap,
	input  wire logic                 port1_power_request,
	input  wire logic                 port2_power_request,
	input  wire logic                 source_over_flag,
	input  wire logic                 port1_short_flag,
	input  wire logic                 port2_short_flag,
	input  wire logic                 port1_over_limit_flag,
	input  wire logic                 port2_over_limit_flag,
	input  wire logic                 port1_raise_flag,
	input  wire logic                 port2_raise_flag,
	input  wire logic                 port1_quota_reached,
	input  wire logic                 port2_quota_reached,
	input  wire logic                 port1_discharge_busy,
	input  wire logic                 port2_discharge_busy,
	output var  logic                 port1_switch_on,
	output var  logic                 port2_switch_on,
	output var  logic                 port1_soft_start,
	output var  logic                 port2_soft_start,
	output var  logic                 port1_short_limit,
	output var  logic                 port2_short_limit,
	output var  uspc_pkg::uspc_limit_t port1_current_limit,
	output var  uspc_pkg::uspc_limit_t port2_current_limit,
	output var  logic                 port1_alert_n_o,
	output var  logic                 port1_alert_n_oe,
	output var  logic                 port2_alert_n_o,
	output var  logic                 port2_alert_n_oe,
	output var  logic                 converter_raise_n_o,
	output var  logic                 converter_raise_n_oe
);
	localparam int RW = $clog2(RISE_CYC + 1);
	localparam int YW = $clog2(CYCLE_CYC + 1);
	localparam int TW = (RW > YW) ? RW : YW;
	localparam logic [TW-1:0] RISE_LAST  = TW'(RISE_CYC - 1);
	localparam logic [TW-1:0] CYCLE_LAST = TW'(CYCLE_CYC - 1);

	function automatic uspc_pkg::uspc_limit_t clamp_limit(
		input uspc_pkg::uspc_limit_t prog,
		input uspc_pkg::uspc_limit_t hw
	);
		clamp_limit = (prog > hw) ? hw : prog;
	endfunction

	// Registers and strap state
	logic [`USPC_DW-1:0]   ctrl;
	logic [`USPC_DW-1:0]   limit;
	logic [1:0]            quota_flag;
	logic                  strap_done;
	logic [3:0]            strap;
	logic [1:0]            sw_q;
	logic [1:0]            soft_q;
	logic [1:0]            short_q;
	logic [1:0]            alert_q;
	logic                  raise_q;
	logic                  drive_low;
	uspc_pkg::uspc_limit_t lim_q [2];
	logic                  ov_exp;
	logic [1:0]            short_exp;
	logic                  raise_hold;

	// Input grouping
	wire [1:0] pin_req   = {port2_power_request, port1_power_request};
	wire [1:0] short_f   = {port2_short_flag, port1_short_flag};
	wire [1:0] over_f    = {port2_over_limit_flag, port1_over_limit_flag};
	wire [1:0] raise_f   = {port2_raise_flag, port1_raise_flag};
	wire [1:0] quota_f   = {port2_quota_reached, port1_quota_reached};
	wire [1:0] dis_busy  = {port2_discharge_busy, port1_discharge_busy};

	// Strap decode
	wire                  active_low = strap[`USPC_STRAP_POL];
	wire                  smbus_mode = !strap[`USPC_STRAP_POL];
	wire uspc_pkg::uspc_limit_t hw_lim = strap[`USPC_LW-1:0];

	// Control fields
	wire       bypass    = ctrl[`USPC_CTRL_BYPASS];
	wire       trip_mode = ctrl[`USPC_CTRL_TRIP];
	wire       auto_rec  = ctrl[`USPC_CTRL_AUTO];
	wire       quota_en  = ctrl[`USPC_CTRL_QEN];

	// Register decode
	wire       sel_ctrl  = (reg_addr == `USPC_ADDR_CTRL);
	wire       sel_limit = (reg_addr == `USPC_ADDR_LIMIT);
	wire       sel_stat  = (reg_addr == `USPC_ADDR_STATUS);
	wire       sel_qclr  = (reg_addr == `USPC_ADDR_QCLR);
	wire [1:0] qclr      = (reg_write & sel_qclr) ? reg_wdata[1:0] : 2'h0;
	// Set wins over clear so a quota event in an enabled cycle is never lost
	wire [1:0] next_quota = (quota_flag & ~qclr) | quota_f;

	wire [`USPC_DW-1:0] status_word =
		(`USPC_DW'(sw_q)        << `USPC_ST_SW) |
		(`USPC_DW'(alert_q)     << `USPC_ST_ALERT) |
		(`USPC_DW'(quota_flag)  << `USPC_ST_QUOTA) |
		(`USPC_DW'(raise_q)     << `USPC_ST_RAISE) |
		(`USPC_DW'(smbus_mode)  << `USPC_ST_SMBUS) |
		(`USPC_DW'(strap)       << `USPC_ST_STRAP) |
		(`USPC_DW'(lim_q[0])    << `USPC_ST_LIM1) |
		(`USPC_DW'(lim_q[1])    << `USPC_ST_LIM2);

	wire [`USPC_DW-1:0] next_rdata =
		!reg_read ? '0 :
		sel_ctrl  ? ctrl :
		sel_limit ? limit :
		sel_stat  ? status_word : '0;

	// Strap caught once, on the first enabled edge after reset
	always_ff @(posedge clk) begin
		if (reset) begin
			strap_done <= 1'b0;
			strap      <= 4'h0;
		end else if (ce && !strap_done) begin
			strap_done <= 1'b1;
			strap      <= mode_limit_strap;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl       <= `USPC_CTRL_RESET;
			limit      <= `USPC_LIMIT_RESET;
			quota_flag <= 2'h0;
			reg_rdata  <= '0;
		end else if (ce) begin
			if (reg_write && sel_ctrl)
				ctrl <= reg_wdata;
			if (reg_write && sel_limit)
				limit <= reg_wdata;
			quota_flag <= next_quota;
			reg_rdata  <= next_rdata;
		end
	end

	// Overvoltage persistence, shared by both ports
	uspc_persist #(
		.CYC (MASK_CYC)
	) u_ov_mask (
		.clk     (clk),
		.reset   (reset),
		.ce      (ce),
		.cond    (source_over_flag),
		.expired (ov_exp)
	);

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_port
			uspc_pkg::uspc_state_t state;
			uspc_pkg::uspc_state_t next_state;
			logic [TW-1:0]         tmr;
			logic                  en_q;

			wire pin_act  = pin_req[p] ^ active_low;
			wire soft_req = ctrl[`USPC_CTRL_SOFT + p];
			wire sa_en    = pin_act;
			wire sm_en    = bypass ? soft_req : (pin_act & soft_req);
			// Enables are not trusted until the strap polarity is known
			wire en       = strap_done & (smbus_mode ? sm_en : sa_en);
			wire en_rise  = en & !en_q;
			wire [1:0] act = ctrl[`USPC_CTRL_ACT + 2*p +: 2];
			wire quota_alert = quota_en & quota_flag[p] & (act == `USPC_ACT_ASSERT);
			wire trip_now = trip_mode & over_f[p] & sw_q[p];
			wire err_now  = ov_exp | short_exp[p] | trip_now;
			wire clear_now = !source_over_flag & !short_f[p] & !over_f[p];
			wire rise_done = (tmr == RISE_LAST);
			wire cyc_done  = (tmr >= CYCLE_LAST);
			wire closing   = (next_state == uspc_pkg::USPC_SOFT) ||
				(next_state == uspc_pkg::USPC_ON);
			wire [TW-1:0] next_tmr = (next_state != state) ? '0 :
				(cyc_done ? tmr : tmr + 1'b1);

			uspc_persist #(
				.CYC (SHORT_CYC)
			) u_short (
				.clk     (clk),
				.reset   (reset),
				.ce      (ce),
				.cond    (short_f[p] & sw_q[p]),
				.expired (short_exp[p])
			);

			always_comb begin
				next_state = state;
				case (state)
					uspc_pkg::USPC_OFF: begin
						if (en_rise && !err_now)
							next_state = uspc_pkg::USPC_SOFT;
						else if (en_rise || ov_exp)
							next_state = uspc_pkg::USPC_ERR;
					end
					uspc_pkg::USPC_SOFT: begin
						if (err_now)
							next_state = uspc_pkg::USPC_ERR;
						else if (!en)
							next_state = uspc_pkg::USPC_OFF;
						else if (rise_done)
							next_state = uspc_pkg::USPC_ON;
					end
					uspc_pkg::USPC_ON: begin
						if (err_now)
							next_state = uspc_pkg::USPC_ERR;
						else if (!en)
							next_state = uspc_pkg::USPC_OFF;
					end
					uspc_pkg::USPC_ERR: begin
						// Latched handling leaves only after the enable is toggled off
						if (auto_rec && cyc_done && clear_now)
							next_state = en ? uspc_pkg::USPC_ON : uspc_pkg::USPC_OFF;
						else if (!auto_rec && !en && clear_now)
							next_state = uspc_pkg::USPC_OFF;
					end
					default: next_state = uspc_pkg::USPC_OFF;
				endcase
			end

			always_ff @(posedge clk) begin
				if (reset) begin
					state <= uspc_pkg::USPC_OFF;
					tmr   <= '0;
					en_q  <= 1'b0;
				end else if (ce) begin
					state <= next_state;
					tmr   <= next_tmr;
					en_q  <= en;
				end
			end

			always_ff @(posedge clk) begin
				if (reset) begin
					sw_q[p]    <= 1'b0;
					soft_q[p]  <= 1'b0;
					short_q[p] <= 1'b0;
					alert_q[p] <= 1'b0;
					lim_q[p]   <= '0;
				end else if (ce) begin
					sw_q[p]    <= closing & en & !dis_busy[p];
					soft_q[p]  <= (next_state == uspc_pkg::USPC_SOFT);
					short_q[p] <= short_f[p] & sw_q[p];
					alert_q[p] <= (next_state == uspc_pkg::USPC_ERR) | quota_alert;
					lim_q[p]   <= clamp_limit(limit[`USPC_LIMIT_STRIDE*p +: `USPC_LW], hw_lim);
				end
			end
		end
	endgenerate

	// Converter_raise_n request from either closed port
	uspc_hold #(
		.HOLD (HOLD_CYC)
	) u_raise (
		.clk    (clk),
		.reset  (reset),
		.ce     (ce),
		.trig   (|(raise_f & sw_q)),
		.active (raise_hold)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			raise_q   <= 1'b0;
			drive_low <= 1'b0;
		end else if (ce) begin
			raise_q   <= raise_hold;
			drive_low <= 1'b0;
		end
	end

	// Open-drain pins only ever pull low; enable marks the asserted level
	assign port1_alert_n_o      = drive_low;
	assign port2_alert_n_o      = drive_low;
	assign port1_alert_n_oe     = alert_q[0];
	assign port2_alert_n_oe     = alert_q[1];
	assign converter_raise_n_o  = drive_low;
	assign converter_raise_n_oe = raise_q;
	assign port1_switch_on      = sw_q[0];
	assign port2_switch_on      = sw_q[1];
	assign port1_soft_start     = soft_q[0];
	assign port2_soft_start     = soft_q[1];
	assign port1_short_limit    = short_q[0];
	assign port2_short_limit    = short_q[1];
	assign port1_current_limit  = lim_q[0];
	assign port2_current_limit  = lim_q[1];
endmodule // uspc_top
`default_nettype wire

/* File: include/uspc_defs.svh */
// Constants for the USB port power switch control block
`ifndef USPC_DEFS_SVH
`define USPC_DEFS_SVH
`define USPC_CLK_NS        5
`define USPC_MASK_NS       5000
`define USPC_SHORT_NS      1000
`define USPC_RISE_NS       10000
`define USPC_CYCLE_NS      20000
`define USPC_HOLD_NS       10000
`define USPC_AW            8
`define USPC_DW            32
`define USPC_ADDR_CTRL     8'h00
`define USPC_ADDR_LIMIT    8'h04
`define USPC_ADDR_STATUS   8'h08
`define USPC_ADDR_QCLR     8'h0C
`define USPC_CTRL_RESET    32'h0000001B
`define USPC_LIMIT_RESET   32'h00000077
`define USPC_CTRL_SOFT     0
`define USPC_CTRL_BYPASS   2
`define USPC_CTRL_TRIP     3
`define USPC_CTRL_AUTO     4
`define USPC_CTRL_QEN      5
`define USPC_CTRL_ACT      6
`define USPC_LIMIT_STRIDE  4
`define USPC_LW            3
`define USPC_STRAP_POL     3
`define USPC_ACT_ASSERT    2'h0
`define USPC_ST_SW         0
`define USPC_ST_ALERT      2
`define USPC_ST_QUOTA      4
`define USPC_ST_RAISE      6
`define USPC_ST_SMBUS      7
`define USPC_ST_STRAP      8
`define USPC_ST_LIM1       12
`define USPC_ST_LIM2       16
`endif

/* File: include/uspc_pkg.sv */
// Types for the USB port power switch control block
package uspc_pkg;
	typedef enum logic [1:0] {
		USPC_OFF,
		USPC_SOFT,
		USPC_ON,
		USPC_ERR
	} uspc_state_t;
	typedef logic [2:0] uspc_limit_t;
endpackage

/* File: test/uspc_hub.sv */
// Hub-side model: power requests out, fault wires sensed
`timescale 1ns/1ps
`default_nettype none
module uspc_hub (
	input  wire logic active_low,
	input  wire logic want1,
	input  wire logic want2,
	input  wire logic alert1_o,
	input  wire logic alert1_oe,
	input  wire logic alert2_o,
	input  wire logic alert2_oe,
	output wire logic req1,
	output wire logic req2,
	output wire logic fault1,
	output wire logic fault2,
	output wire logic serial_clock_in,
	output wire logic serial_data_io
);
	// Serial bus not modelled; a stand-alone board ties both pins low
	assign serial_clock_in = 1'h0;
	assign serial_data_io  = 1'h0;
	// Requests are levels; polarity follows the strap
	assign req1 = want1 ^ active_low;
	assign req2 = want2 ^ active_low;
	// Pulled-up wire, as a shared-pin hub senses it
	assign fault1 = !(alert1_oe ? alert1_o : 1'h1);
	assign fault2 = !(alert2_oe ? alert2_o : 1'h1);
endmodule // uspc_hub
`default_nettype wire

/* File: test/uspc_top_assertions.sv */
// Port-level assertions for the switch control block
`timescale 1ns/1ps
`default_nettype none
module uspc_top_assertions #(
	parameter int MASK_CYC  = 8,
	parameter int SHORT_CYC = 4,
	parameter int RISE_CYC  = 8,
	parameter int CYCLE_CYC = 16,
	parameter int HOLD_CYC  = 8
) (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic [3:0] mode_limit_strap,
	input wire logic       source_over_flag,
	input wire logic       port1_short_flag,
	input wire logic       port1_over_limit_flag,
	input wire logic       port1_raise_flag,
	input wire logic       port2_raise_flag,
	input wire logic       port1_discharge_busy,
	input wire logic       port1_switch_on,
	input wire logic       port2_switch_on,
	input wire logic       port1_soft_start,
	input wire logic       port1_short_limit,
	input wire logic [2:0] port1_current_limit,
	input wire logic       port1_alert_n_o,
	input wire logic       port1_alert_n_oe,
	input wire logic       port2_alert_n_oe,
	input wire logic       converter_raise_n_o,
	input wire logic       converter_raise_n_oe
);
	// Repeat counts match the bench's shortened parameters
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence ov_held;
		source_over_flag [*8];
	endsequence
	sequence both_faulted;
		port1_alert_n_oe && port2_alert_n_oe && !port1_switch_on && !port2_switch_on;
	endsequence
	sequence soft_run;
		(port1_switch_on && port1_soft_start) [*8];
	endsequence
	a_ov_both_fault: assert property (ov_held |-> ##[1:4] both_faulted)
		else $error("overvoltage did not fault both ports");
	a_soft_full_len: assert property ($rose(port1_soft_start) |-> soft_run)
		else $error("soft start too short");
	a_discharge_off: assert property (port1_discharge_busy [*2] |-> !port1_switch_on)
		else $error("switch closed during discharge");
	a_drains_low: assert property (!port1_alert_n_o && !converter_raise_n_o)
		else $error("open-drain output drives high");
	a_raise_follow: assert property (port1_raise_flag || port2_raise_flag |-> ##[1:2] converter_raise_n_oe)
		else $error("converter_raise_n not asserted");
	a_raise_min_hold: assert property ($rose(converter_raise_n_oe) |-> converter_raise_n_oe [*8])
		else $error("converter_raise_n released early");
	a_limit_clamped: assert property (port1_current_limit <= mode_limit_strap[2:0])
		else $error("limit above strap limit");
	a_short_engage: assert property (port1_short_flag && port1_switch_on |=> port1_short_limit)
		else $error("short limiter not engaged");
	a_short_error: assert property ((port1_short_flag && port1_switch_on) [*4] |-> ##[1:4] port1_alert_n_oe)
		else $error("lasting short not faulted");
	a_trip_opens: assert property (port1_over_limit_flag && port1_switch_on |-> ##[1:3]
		(port1_alert_n_oe && !port1_switch_on))
		else $error("trip did not open switch");
endmodule // uspc_top_assertions
`default_nettype wire

/* File: test/uspc_top_tb.sv */
// Self-checking bench for the switch control block
`timescale 1ns/1ps
`default_nettype none
module uspc_top_tb;
	typedef struct packed {
		logic [3:0] strap;
		logic       want;
		logic       sw;
	} uspc_row_t;
	localparam uspc_row_t ROWS [8] = '{'{4'h0, 1'h1, 1'h1}, '{4'h0, 1'h0, 1'h0}, '{4'h7, 1'h1, 1'h1},
		'{4'h3, 1'h0, 1'h0}, '{4'h8, 1'h1, 1'h1}, '{4'h8, 1'h0, 1'h0}, '{4'hF, 1'h1, 1'h1}, '{4'hB, 1'h0, 1'h0}};
	logic        clk, reset, ce, reg_write, reg_read, want1, want2, fault1, fault2;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [3:0]  mode_limit_strap;
	logic        port1_power_request, port2_power_request, source_over_flag;
	logic        port1_short_flag, port2_short_flag, port1_over_limit_flag, port2_over_limit_flag;
	logic        port1_raise_flag, port2_raise_flag, port1_quota_reached, port2_quota_reached;
	logic        port1_discharge_busy, port2_discharge_busy, port1_switch_on, port2_switch_on;
	logic        port1_soft_start, port2_soft_start, port1_short_limit, port2_short_limit;
	logic [2:0]  port1_current_limit, port2_current_limit;
	logic        port1_alert_n_o, port1_alert_n_oe, port2_alert_n_o, port2_alert_n_oe;
	logic        converter_raise_n_o, converter_raise_n_oe;
	int          miscompares = 0;
	int          samples_checked = 0;
	uspc_top #(.MASK_CYC(8), .SHORT_CYC(4), .RISE_CYC(8), .CYCLE_CYC(16), .HOLD_CYC(8)) uspc_top_inst (
		.clk, .reset, .ce, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .mode_limit_strap,
		.port1_power_request, .port2_power_request, .source_over_flag, .port1_short_flag, .port2_short_flag,
		.port1_over_limit_flag, .port2_over_limit_flag, .port1_raise_flag, .port2_raise_flag,
		.port1_quota_reached, .port2_quota_reached, .port1_discharge_busy, .port2_discharge_busy,
		.port1_switch_on, .port2_switch_on, .port1_soft_start, .port2_soft_start, .port1_short_limit,
		.port2_short_limit, .port1_current_limit, .port2_current_limit, .port1_alert_n_o, .port1_alert_n_oe,
		.port2_alert_n_o, .port2_alert_n_oe, .converter_raise_n_o, .converter_raise_n_oe);
	uspc_hub uspc_hub_inst (.active_low(mode_limit_strap[3]), .want1, .want2, .alert1_o(port1_alert_n_o),
		.alert1_oe(port1_alert_n_oe), .alert2_o(port2_alert_n_o), .alert2_oe(port2_alert_n_oe),
		.req1(port1_power_request), .req2(port2_power_request), .fault1, .fault2,
		.serial_clock_in(), .serial_data_io());
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [2:0] got, input logic [2:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_write <= 1'h1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_write <= 1'h0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_read <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'h0;
		#1 samples_checked++;
		if (reg_rdata !== e) begin
			miscompares++;
			$display("unexpected at %0t: read %h, expected %h", $time, reg_rdata, e);
		end
	endtask
	task automatic rst(input logic [3:0] s);
		@(posedge clk);
		reset <= 1'h1;
		mode_limit_strap <= s;
		cyc(3);
		reset <= 1'h0;
	endtask
	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		cyc(20000);
		miscompares++;
		$display("unexpected at %0t: run hung", $time);
		final_report();
	end
	initial begin
		{reset, ce} = 2'h3;
		{reg_write, reg_read, reg_addr, reg_wdata, mode_limit_strap, want1, want2} = '0;
		{source_over_flag, port1_short_flag, port2_short_flag, port1_over_limit_flag, port2_over_limit_flag} = '0;
		{port1_raise_flag, port2_raise_flag, port1_quota_reached, port2_quota_reached} = '0;
		{port1_discharge_busy, port2_discharge_busy} = '0;
		foreach (ROWS[i]) begin
			rst(ROWS[i].strap);
			want1 <= ROWS[i].want;
			want2 <= ROWS[i].want;
			cyc(20);
			#1 chk(port1_switch_on, ROWS[i].sw);
			chk(port2_switch_on, ROWS[i].sw);
			rd(8'h08, {13'h0, ROWS[i].strap[2:0], 1'h0, ROWS[i].strap[2:0], ROWS[i].strap,
				~ROWS[i].strap[3], 5'h0, {2{ROWS[i].sw}}});
			$display("row %0d done", i);
		end
		rst(4'h4);
		want1 <= 1'h1;
		want2 <= 1'h1;
		cyc(20);
		rd(8'h00, 32'h0000001B);
		rd(8'h04, 32'h00000077);
		rd(8'h10, 32'h00000000);
		// Strap moves after capture; the captured value must stay
		// Bit 3 kept, so the hub keeps its request polarity
		@(posedge clk);
		mode_limit_strap <= 4'h6;
		wr(8'h04, 32'h00000027);
		cyc(3);
		rd(8'h08, 32'h00024483);
		chk(port1_current_limit, 3'h4);
		chk(port2_current_limit, 3'h2);
		wr(8'h00, 32'h0000001F);
		want1 <= 1'h0;
		want2 <= 1'h0;
		cyc(6);
		#1 chk(port1_switch_on, 1'h1);
		wr(8'h00, 32'h0000001D);
		cyc(4);
		#1 chk(port2_switch_on, 1'h0);
		wr(8'h00, 32'h0000001B);
		want1 <= 1'h1;
		want2 <= 1'h1;
		cyc(4);
		#1 chk(port2_soft_start, 1'h1);
		cyc(16);
		#1 chk(port2_switch_on, 1'h1);
		chk(port2_soft_start, 1'h0);
		@(posedge clk);
		port1_discharge_busy <= 1'h1;
		cyc(3);
		#1 chk(port1_switch_on, 1'h0);
		@(posedge clk);
		port1_discharge_busy <= 1'h0;
		port2_raise_flag <= 1'h1;
		@(posedge clk);
		port2_raise_flag <= 1'h0;
		cyc(6);
		#1 chk(converter_raise_n_oe, 1'h1);
		cyc(14);
		#1 chk(converter_raise_n_oe, 1'h0);
		chk(port1_switch_on, 1'h1);
		$display("enable tests done");
		@(posedge clk);
		port1_over_limit_flag <= 1'h1;
		@(posedge clk);
		port1_over_limit_flag <= 1'h0;
		cyc(3);
		#1 chk(fault1, 1'h1);
		chk(fault2, 1'h0);
		cyc(24);
		#1 chk(port1_switch_on, 1'h1);
		chk(fault1, 1'h0);
		@(posedge clk);
		port1_short_flag <= 1'h1;
		port2_short_flag <= 1'h1;
		@(posedge clk);
		port2_short_flag <= 1'h0;
		#1 chk(port2_short_limit, 1'h1);
		cyc(1);
		#1 chk(port1_short_limit, 1'h1);
		cyc(6);
		#1 chk(fault1, 1'h1);
		@(posedge clk);
		port1_short_flag <= 1'h0;
		source_over_flag <= 1'h1;
		cyc(5);
		source_over_flag <= 1'h0;
		cyc(24);
		#1 chk(port1_switch_on, 1'h1);
		chk(fault2, 1'h0);
		@(posedge clk);
		source_over_flag <= 1'h1;
		cyc(12);
		#1 chk(fault2, 1'h1);
		chk(port2_switch_on, 1'h0);
		@(posedge clk);
		source_over_flag <= 1'h0;
		cyc(24);
		#1 chk(port2_switch_on, 1'h1);
		$display("fault tests done");
		wr(8'h00, 32'h0000023B);
		port1_quota_reached <= 1'h1;
		port2_quota_reached <= 1'h1;
		@(posedge clk);
		{port1_quota_reached, port2_quota_reached} <= 2'h0;
		cyc(20);
		#1 chk(fault1, 1'h1);
		chk(fault2, 1'h0);
		wr(8'h0C, 32'h00000003);
		cyc(3);
		#1 chk(fault1, 1'h0);
		$display("quota test done");
		// Quota event while frozen must leave no trace
		@(posedge clk);
		ce <= 1'h0;
		port1_quota_reached <= 1'h1;
		cyc(2);
		port1_quota_reached <= 1'h0;
		ce <= 1'h1;
		cyc(3);
		#1 chk(fault1, 1'h0);
		chk(port1_switch_on, 1'h1);
		$display("clock enable test done");
		final_report();
	end
endmodule // uspc_top_tb
bind uspc_top uspc_top_assertions #(.MASK_CYC(MASK_CYC), .SHORT_CYC(SHORT_CYC), .RISE_CYC(RISE_CYC),
	.CYCLE_CYC(CYCLE_CYC), .HOLD_CYC(HOLD_CYC)) uspc_top_assertions_inst (.clk, .reset, .mode_limit_strap,
	.source_over_flag, .port1_short_flag, .port1_over_limit_flag, .port1_raise_flag, .port2_raise_flag,
	.port1_discharge_busy, .port1_switch_on, .port2_switch_on, .port1_soft_start, .port1_short_limit,
	.port1_current_limit, .port1_alert_n_o, .port1_alert_n_oe, .port2_alert_n_oe, .converter_raise_n_o,
	.converter_raise_n_oe);
`default_nettype wire
